// ### rsc_pkg.sv
// Constants and types for the reset source and start-up controller.
// Assumes a single 20 MHz bus clock and an AHB-Lite register bus.
package rsc_pkg;

   localparam int unsigned CLK_HZ = 20_000_000;

   // Register byte addresses
   localparam logic [7:0] ADDR_CAUSE  = 8'h00;
   localparam logic [7:0] ADDR_CFG    = 8'h04;
   localparam logic [7:0] ADDR_CTRL   = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_ST = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MK = 8'h14;

   // Cause register bit positions
   localparam int CAUSE_STACK_OVERFLOW_FLAG = 7;
   localparam int CAUSE_STACK_UNDERFLOW_FLAG = 6;
   localparam int CAUSE_WDT    = 4;
   localparam int CAUSE_MASTER_CLEAR_PIN   = 3;
   localparam int CAUSE_RI_N   = 2;
   localparam int CAUSE_POR_N  = 1;
   localparam int CAUSE_BOR_N  = 0;
   localparam logic [7:0] CAUSE_RST = 8'h07;

   // Config bits (stand-in for the configuration words)
   localparam int CFG_LOW_POWER_BROWNOUT_DETECTOR_N  = 0;
   localparam int CFG_MASTER_CLEAR_ENABLE_BIT    = 1;
   localparam int CFG_LVP      = 2;
   localparam int CFG_STACK_RESET_ENABLE_BIT   = 3;
   localparam int CFG_POWERUP_TIMER_ENABLE_N_N  = 4;
   localparam int CFG_BROWNOUT_SELECT_FIELD_LO = 5;
   localparam int CFG_BROWNOUT_SELECT_FIELD_HI = 6;
   // Erased state: all ones, so the low-power detector is off
   localparam logic [6:0] CFG_RST = 7'h7F;

   // Control register
   localparam int CTRL_PULLUP = 0;
   localparam int CTRL_RESET  = 1;
   localparam int CTRL_WDTCLR = 2;

   // Status register: timeout_flag_n and powerdown_flag_n
   localparam int STAT_TO_N = 0;
   localparam int STAT_PD_N = 1;
   localparam int STAT_RUN  = 2;

   // Interrupt event bits
   localparam int IRQ_W       = 6;
   localparam int IRQ_BROWN   = 0;
   localparam int IRQ_MASTER_CLEAR_PIN    = 1;
   localparam int IRQ_WDT     = 2;
   localparam int IRQ_SWRST   = 3;
   localparam int IRQ_STACK   = 4;
   localparam int IRQ_RUN     = 5;

   localparam int unsigned RELEASE_CYC = 10;
   localparam int unsigned GLITCH_CYC  = 4;
   localparam int unsigned PWRT_LF_CYC = 2048;
   localparam int unsigned WDT_CYC     = 65536;

   typedef enum logic [1:0] {
      RSC_HOLD, RSC_WAIT, RSC_DELAY, RSC_RUN
   } rsc_state_t;

endpackage

// ### rsc_pin_if.sv
// Carries the filtered master-clear pin between filter and top.
// Assumes both ends on hclk.
`timescale 1ns/1ns
interface rsc_pin_if;
   logic low;
   logic enabled;
   modport filt (output low, input enabled);
   modport core (input low, output enabled);
endinterface

// ### rsc_glitch_filter.sv
// Master-clear pin synchroniser and glitch filter.
// Assumes the raw pin is asynchronous to hclk.
`timescale 1ns/1ns
module rsc_glitch_filter #(
   parameter int unsigned FILT = rsc_pkg::GLITCH_CYC
) (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Pin
   input  wire logic pin_in,
   rsc_pin_if.filt   pif
);
   import rsc_pkg::*;

   logic       s1_q;
   logic       s2_q;
   logic [7:0] cnt_q;
   logic       low_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
      end
   end

   // Short pulses never reach the filtered level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 8'h00;
         low_q <= 1'b0;
      end else if ((!s2_q) == low_q) begin
         cnt_q <= 8'h00;
      end else if (cnt_q == 8'(FILT - 1)) begin
         cnt_q <= 8'h00;
         low_q <= !s2_q;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   // Disabled function reads as released
   assign pif.low = low_q & pif.enabled;
endmodule

// ### rsc_pwrt.sv
// Power-up timer counted on the free-running low-frequency clock.
// Assumes lf_clk is a slow pin-level signal, sampled into hclk.
`timescale 1ns/1ns
module rsc_pwrt #(
   parameter int unsigned LF_CYC = rsc_pkg::PWRT_LF_CYC
) (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Control
   input  wire logic lf_clk,
   input  wire logic start,
   output logic      done
);
   import rsc_pkg::*;

   logic        l1_q;
   logic        l2_q;
   logic        l3_q;
   logic [15:0] cnt_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         l1_q <= 1'b0;
         l2_q <= 1'b0;
         l3_q <= 1'b0;
      end else begin
         l1_q <= lf_clk;
         l2_q <= l1_q;
         l3_q <= l2_q;
      end
   end

   // Counts slow-clock edges, independent of master clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 16'h0000;
         done  <= 1'b0;
      end else if (start) begin
         cnt_q <= 16'h0000;
         done  <= 1'b0;
      end else if (!done && l2_q && !l3_q) begin
         if (cnt_q == 16'(LF_CYC - 1)) begin
            done <= 1'b1;
         end
         cnt_q <= cnt_q + 16'h0001;
      end
   end
endmodule

// ### rsc_top.sv
// Reset source gathering, cause flags and start-up sequencing.
// Assumes one 20 MHz hclk, AHB-Lite slave, pins async to hclk.
//
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
module rsc_top #(
   parameter int unsigned PWRT_LF = rsc_pkg::PWRT_LF_CYC,
   parameter int unsigned WDT_TO  = rsc_pkg::WDT_CYC,
   parameter int unsigned FILT    = rsc_pkg::GLITCH_CYC
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Pins and analog flags
   input  wire logic        master_clear_pin_pin_in,
   output logic             master_clear_pin_pin_out,
   output logic             master_clear_pin_pin_oe_n,
   output logic             master_clear_pin_pullup_en,
   input  wire logic        lp_brownout_low,
   input  wire logic        prog_mode,
   input  wire logic        lf_clk,
   // Core events
   input  wire logic        stack_overflow,
   input  wire logic        stack_underflow,
   // Outputs
   output logic             core_reset,
   output logic             irq
);
   import rsc_pkg::*;

   rsc_pin_if  pif ();
   rsc_state_t state_q;
   logic       pwrt_start;
   logic       pwrt_done;
   logic [6:0] cfg_q;
   logic [2:0] ctrl_q;
   logic [7:0] cause_q;
   logic [1:0] stat_q;
   logic [IRQ_W-1:0] ist_q;
   logic [IRQ_W-1:0] imk_q;
   logic [IRQ_W-1:0] ev;
   logic [3:0] rel_q;
   logic [16:0] wdt_q;
   logic       bo1_q, bo2_q, pm1_q, pm2_q, pm3_q;
   logic       so1_q, so2_q, su1_q, su2_q;
   logic       ap_q, aw_q;
   logic [7:0] aa_q;
   logic       lp_low, master_clear_pin_on, master_clear_pin_low, pm_exit, stk_ev;
   logic       wdt_ev, sw_ev, por_ev, run_pulse;

   rsc_glitch_filter #(.FILT(FILT)) u_filt (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin_in  (master_clear_pin_pin_in),
      .pif     (pif)
   );

   rsc_pwrt #(.LF_CYC(PWRT_LF)) u_pwrt (
      .hclk    (hclk),
      .hresetn (hresetn),
      .lf_clk  (lf_clk),
      .start   (pwrt_start),
      .done    (pwrt_done)
   );

   // Async pin inputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {bo1_q, bo2_q, pm1_q, pm2_q, pm3_q} <= 5'h00;
         {so1_q, so2_q, su1_q, su2_q} <= 4'h0;
      end else begin
         bo1_q <= lp_brownout_low;
         bo2_q <= bo1_q;
         pm1_q <= prog_mode;
         pm2_q <= pm1_q;
         pm3_q <= pm2_q;
         so1_q <= stack_overflow;
         so2_q <= so1_q;
         su1_q <= stack_underflow;
         su2_q <= su1_q;
      end
   end

   // Detector enable is active-low config bit
   assign lp_low  = bo2_q & !cfg_q[CFG_LOW_POWER_BROWNOUT_DETECTOR_N];
   assign master_clear_pin_on = cfg_q[CFG_MASTER_CLEAR_ENABLE_BIT] | cfg_q[CFG_LVP];
   assign pif.enabled = master_clear_pin_on;
   assign master_clear_pin_low = pif.low;
   assign pm_exit  = pm3_q & !pm2_q;
   assign stk_ev   = cfg_q[CFG_STACK_RESET_ENABLE_BIT] & (so2_q | su2_q)
                     & (state_q == RSC_RUN);
   assign wdt_ev   = (state_q == RSC_RUN) && (wdt_q == 17'(WDT_TO - 1));
   assign sw_ev    = ctrl_q[CTRL_RESET];
   // Programming exit treated as power-on
   assign por_ev   = pm_exit | pm2_q;
   assign pwrt_start = lp_low | por_ev;

   // Start-up sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= RSC_HOLD;
         rel_q   <= 4'h0;
      end else if (lp_low || por_ev) begin
         state_q <= RSC_HOLD;
         rel_q   <= 4'h0;
      end else if (wdt_ev || sw_ev || stk_ev) begin
         state_q <= RSC_WAIT;
         rel_q   <= 4'h0;
      end else begin
         unique case (state_q)
            RSC_HOLD: begin
               // Timer runs even while pin is low
               if (pwrt_done || cfg_q[CFG_POWERUP_TIMER_ENABLE_N_N]) begin
                  state_q <= RSC_WAIT;
               end
            end
            RSC_WAIT: begin
               if (!master_clear_pin_low) begin
                  state_q <= RSC_DELAY;
                  rel_q   <= 4'h0;
               end
            end
            RSC_DELAY: begin
               if (master_clear_pin_low) begin
                  state_q <= RSC_WAIT;
               end else if (rel_q == 4'(RELEASE_CYC - 1)) begin
                  state_q <= RSC_RUN;
               end else begin
                  rel_q <= rel_q + 4'h1;
               end
            end
            RSC_RUN: begin
               if (master_clear_pin_low) begin
                  state_q <= RSC_WAIT;
               end
            end
         endcase
      end
   end

   assign run_pulse = (state_q == RSC_DELAY) && !master_clear_pin_low
                      && (rel_q == 4'(RELEASE_CYC - 1));

   // Watchdog: software clear restarts count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdt_q <= 17'h00000;
      end else if (state_q != RSC_RUN || ctrl_q[CTRL_WDTCLR] || wdt_ev) begin
         wdt_q <= 17'h00000;
      end else begin
         wdt_q <= wdt_q + 17'h00001;
      end
   end

   // Outputs; pin never driven
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_reset     <= 1'b1;
         master_clear_pin_pin_out   <= 1'b0;
         master_clear_pin_pin_oe_n  <= 1'b1;
         master_clear_pin_pullup_en <= 1'b0;
      end else begin
         core_reset     <= !(state_q == RSC_RUN) || wdt_ev || sw_ev
                           || stk_ev || lp_low || por_ev || master_clear_pin_low;
         master_clear_pin_pin_out   <= 1'b0;
         master_clear_pin_pin_oe_n  <= 1'b1;
         master_clear_pin_pullup_en <= master_clear_pin_on ? 1'b1 : ctrl_q[CTRL_PULLUP];
      end
   end

   // AHB-Lite address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_q <= 1'b0;
         aw_q <= 1'b0;
         aa_q <= 8'h00;
      end else if (hready) begin
         ap_q <= hsel & htrans[1];
         aw_q <= hwrite;
         aa_q <= haddr;
      end
   end

   // Config, control; control strobes self-clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q  <= CFG_RST;
         ctrl_q <= 3'h0;
         imk_q  <= '0;
      end else begin
         ctrl_q[CTRL_RESET]  <= 1'b0;
         ctrl_q[CTRL_WDTCLR] <= 1'b0;
         if (ap_q && aw_q) begin
            unique case (aa_q)
               ADDR_CFG:    cfg_q  <= hwdata[6:0];
               ADDR_CTRL:   ctrl_q <= hwdata[2:0];
               ADDR_IRQ_MK: imk_q  <= hwdata[IRQ_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // Cause and status flags: hardware event wins over software write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cause_q <= CAUSE_RST;
         stat_q  <= 2'h3;
      end else begin
         if (ap_q && aw_q && aa_q == ADDR_CAUSE) begin
            cause_q <= hwdata[7:0];
         end
         if (lp_low) begin
            cause_q[CAUSE_BOR_N] <= 1'b0;
         end
         if (por_ev) begin
            cause_q[CAUSE_POR_N] <= 1'b0;
         end
         if (sw_ev) begin
            cause_q[CAUSE_RI_N] <= 1'b0;
         end
         if (state_q == RSC_RUN && master_clear_pin_low) begin
            cause_q[CAUSE_MASTER_CLEAR_PIN] <= 1'b1;
         end
         if (stk_ev && so2_q) begin
            cause_q[CAUSE_STACK_OVERFLOW_FLAG] <= 1'b1;
         end
         if (stk_ev && su2_q) begin
            cause_q[CAUSE_STACK_UNDERFLOW_FLAG] <= 1'b1;
         end
         if (wdt_ev) begin
            cause_q[CAUSE_WDT] <= 1'b1;
            stat_q <= 2'h2;
         end else if (ctrl_q[CTRL_WDTCLR] || por_ev) begin
            stat_q <= 2'h3;
         end
      end
   end

   assign ev = {run_pulse, stk_ev, sw_ev, wdt_ev,
                (state_q == RSC_RUN) & master_clear_pin_low, lp_low};

   // Sticky events, write one to clear; set wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ist_q <= '0;
      end else begin
         if (ap_q && aw_q && aa_q == ADDR_IRQ_ST) begin
            ist_q <= (ist_q & ~hwdata[IRQ_W-1:0]) | ev;
         end else begin
            ist_q <= ist_q | ev;
         end
      end
   end

   // Read data, always OKAY, no wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         irq       <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         irq       <= |(ist_q & imk_q);
         hrdata    <= 32'h0000_0000;
         if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr)
               ADDR_CAUSE:  hrdata <= {24'h0, cause_q};
               ADDR_CFG:    hrdata <= {25'h0, cfg_q};
               ADDR_CTRL:   hrdata <= {31'h0, ctrl_q[CTRL_PULLUP]};
               ADDR_STATUS: hrdata <= {29'h0, state_q == RSC_RUN, stat_q};
               ADDR_IRQ_ST: hrdata <= {26'h0, ist_q};
               ADDR_IRQ_MK: hrdata <= {26'h0, imk_q};
               default:     hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// ### rsc_sva.sv
// Port assertions for the reset controller.
// Assumes one hclk domain; bound onto rsc_top.
`timescale 1ns/1ns
module rsc_sva #(
   parameter int unsigned PWRT_LF = rsc_pkg::PWRT_LF_CYC,
   parameter int unsigned WDT_TO  = rsc_pkg::WDT_CYC,
   parameter int unsigned FILT    = rsc_pkg::GLITCH_CYC
) (
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // Bus
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   // Pins and events
   input wire logic        master_clear_pin_pin_in,
   input wire logic        master_clear_pin_pin_out,
   input wire logic        master_clear_pin_pin_oe_n,
   input wire logic        master_clear_pin_pullup_en,
   input wire logic        lp_brownout_low,
   input wire logic        prog_mode,
   input wire logic        stack_overflow,
   input wire logic        stack_underflow,
   input wire logic        core_reset
);
   import rsc_pkg::*;
   logic       wr_q;
   logic [7:0] addr_q;
   logic [6:0] cfg_q;
   logic       pu_q;
   logic       master_clear_pin_en;
   // Shadow of config, so pin rules know the mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q   <= 1'b0;
         addr_q <= 8'h00;
      end else begin
         wr_q   <= hsel && hready && htrans[1] && hwrite;
         addr_q <= haddr;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= CFG_RST;
         pu_q  <= 1'b0;
      end else if (wr_q && addr_q == ADDR_CFG) begin
         cfg_q <= hwdata[6:0];
      end else if (wr_q && addr_q == ADDR_CTRL) begin
         pu_q  <= hwdata[CTRL_PULLUP];
      end
   end
   assign master_clear_pin_en = cfg_q[CFG_MASTER_CLEAR_ENABLE_BIT] || cfg_q[CFG_LVP];
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_PIN_NEVER_DRIVEN:
      assert property (master_clear_pin_pin_oe_n && !master_clear_pin_pin_out)
      else $error("master clear pin driven");
   AST_PULLUP_ON:
      assert property (master_clear_pin_en [*3] |-> master_clear_pin_pullup_en)
      else $error("pull-up off while master clear on");
   AST_PULLUP_SW:
      assert property ((!master_clear_pin_en && pu_q == $past(pu_q)) [*3]
         |-> master_clear_pin_pullup_en == pu_q)
      else $error("pull-up not under software");
   AST_HOLD_PIN_LOW:
      assert property ((master_clear_pin_en && !master_clear_pin_pin_in) [*8]
         |-> ##[1:4] core_reset)
      else $error("pin low did not hold reset");
   AST_GLITCH_IGNORED:
      assert property (!core_reset && master_clear_pin_pin_in ##1 !master_clear_pin_pin_in [*2]
         ##1 master_clear_pin_pin_in |=> !core_reset [*8])
      else $error("short pulse caused reset");
   AST_LP_BROWNOUT:
      assert property ((!cfg_q[CFG_LOW_POWER_BROWNOUT_DETECTOR_N] && lp_brownout_low) [*4]
         |-> ##[0:3] core_reset)
      else $error("brown-out did not hold reset");
   AST_STACK_RESET:
      assert property (cfg_q[CFG_STACK_RESET_ENABLE_BIT]
         && $rose(stack_overflow || stack_underflow)
         |-> ##[1:6] core_reset)
      else $error("stack fault did not reset");
   AST_PROG_HOLD:
      assert property (prog_mode [*3] |-> ##[0:3] core_reset)
      else $error("programming mode not in reset");
   AST_SW_RESET:
      assert property (wr_q && addr_q == ADDR_CTRL && hwdata[CTRL_RESET]
         |-> ##[1:4] core_reset)
      else $error("reset strobe ignored");
   AST_RELEASE_LATE:
      assert property ($fell(core_reset) && master_clear_pin_en
         |-> $past(master_clear_pin_pin_in, 10) && master_clear_pin_pin_in)
      else $error("start too soon after pin release");
endmodule
bind rsc_top rsc_sva #(
   .PWRT_LF(PWRT_LF), .WDT_TO(WDT_TO), .FILT(FILT)
) chk_u (
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
   .master_clear_pin_pin_in, .master_clear_pin_pin_out, .master_clear_pin_pin_oe_n, .master_clear_pin_pullup_en,
   .lp_brownout_low, .prog_mode, .stack_overflow, .stack_underflow,
   .core_reset
);

// ### rsc_master_clear_pin_model.sv
// Board around the master-clear pin: button and wire.
// Assumes the bench presses the button on hclk edges.
`timescale 1ns/1ns
module rsc_master_clear_pin_model (
   // Clock
   input  wire logic hclk,
   // Bench control
   input  wire logic press,
   // Device pad
   input  wire logic pullup_en,
   input  wire logic pin_oe_n,
   input  wire logic pin_out,
   output logic      pin
);
   logic last_q = 1'b0;
   always_ff @(posedge hclk) last_q <= pin;
   always_comb begin
      if (!pin_oe_n) begin
         pin = pin_out;
      end else if (press) begin
         pin = 1'b0;
      end else if (pullup_en) begin
         pin = 1'b1;
      end else begin
         // Floating pin: toggles so no level is trusted
         pin = ~last_q;
      end
   end
endmodule

// ### rsc_top_tb_top.sv
// Self-checking bench for the reset controller.
// Assumes rsc_top, its bound checker and the pin model.
`timescale 1ns/1ns
module rsc_top_tb_top;
   import rsc_pkg::*;
   localparam int unsigned LF  = 4;
   localparam int unsigned WDT = 200;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, r;
   logic        hready, hreadyout, hresp, pin, pout, oe_n, pu;
   logic        lpb = 1'b0, prog = 1'b0, lf_clk = 1'b0;
   logic        ovf = 1'b0, unf = 1'b0, press = 1'b0;
   logic        core_reset, irq;
   int          err_count = 0, samples_checked = 0, n;
   assign hready = hreadyout;
   rsc_top #(.PWRT_LF(LF), .WDT_TO(WDT), .FILT(4)) dut_u (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hrdata, .hreadyout, .hresp,
      .master_clear_pin_pin_in(pin), .master_clear_pin_pin_out(pout), .master_clear_pin_pin_oe_n(oe_n),
      .master_clear_pin_pullup_en(pu), .lp_brownout_low(lpb), .prog_mode(prog),
      .lf_clk, .stack_overflow(ovf), .stack_underflow(unf),
      .core_reset, .irq);
   rsc_master_clear_pin_model pm_u (.hclk, .press, .pullup_en(pu),
      .pin_oe_n(oe_n), .pin_out(pout), .pin);
   initial begin
      forever #25 hclk = ~hclk;
   end
   // Slow clock, eight bus clocks a period
   initial begin
      forever #200 lf_clk = ~lf_clk;
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wait_rst(input logic v);
      n = 0;
      while (core_reset !== v && n < 5000) begin
         @(posedge hclk);
         n++;
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge hclk);
   endtask
   task automatic t_boot;
      bus(1'b0, ADDR_CFG, 32'h0);
      chk(r, CFG_RST);
      bus(1'b0, ADDR_CAUSE, 32'h0);
      chk(r, CAUSE_RST);
      chk(hresp, 1'b0);
      bus(1'b0, 8'h40, 32'h0);
      chk(r, 32'h0);
      wait_rst(1'b0);
      chk(core_reset, 1'b0);
      chk(pu, 1'b1);
   endtask
   task automatic t_pin;
      bus(1'b1, ADDR_CTRL, 32'h4);
      press <= 1'b1;
      wait_rst(1'b1);
      chk(core_reset, 1'b1);
      chk(oe_n, 1'b1);
      cyc(20);
      press <= 1'b0;
      wait_rst(1'b0);
      chk(n >= 10 && n <= 24, 1'b1);
      bus(1'b1, ADDR_CTRL, 32'h4);
      press <= 1'b1;
      cyc(2);
      press <= 1'b0;
      cyc(20);
      chk(core_reset, 1'b0);
   endtask
   task automatic t_off;
      bus(1'b1, ADDR_CFG, 32'h79);
      bus(1'b1, ADDR_CTRL, 32'h1);
      cyc(2);
      chk(pu, 1'b1);
      press <= 1'b1;
      cyc(20);
      chk(core_reset, 1'b0);
      press <= 1'b0;
      bus(1'b1, ADDR_CTRL, 32'h0);
      cyc(2);
      chk(pu, 1'b0);
      bus(1'b1, ADDR_CFG, 32'h7D);
      cyc(2);
      chk(pu, 1'b1);
      bus(1'b1, ADDR_CFG, 32'h7F);
   endtask
   task automatic t_sw;
      bus(1'b1, ADDR_CTRL, 32'h2);
      wait_rst(1'b1);
      chk(core_reset, 1'b1);
      wait_rst(1'b0);
      bus(1'b0, ADDR_CAUSE, 32'h0);
      chk(r[CAUSE_RI_N], 1'b0);
      bus(1'b1, ADDR_CAUSE, CAUSE_RST);
   endtask
   task automatic t_stack;
      // First pass masked, second pass unmasked
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, ADDR_IRQ_ST, 32'h3F);
         bus(1'b1, ADDR_IRQ_MK, 32'(i) << IRQ_STACK);
         ovf <= (i == 0);
         unf <= (i == 1);
         wait_rst(1'b1);
         ovf <= 1'b0;
         unf <= 1'b0;
         wait_rst(1'b0);
         chk(irq, i[0]);
         bus(1'b0, ADDR_CAUSE, 32'h0);
         chk(r[7:6], (i == 1) ? 2'h1 : 2'h2);
         bus(1'b1, ADDR_CAUSE, CAUSE_RST);
      end
      bus(1'b1, ADDR_IRQ_ST, 32'h3F);
      // Clear lands at the data edge, the output one edge later
      cyc(2);
      chk(irq, 1'b0);
   endtask
   task automatic t_lp;
      bus(1'b1, ADDR_CTRL, 32'h4);
      lpb <= 1'b1;
      cyc(10);
      chk(core_reset, 1'b0);
      lpb <= 1'b0;
      bus(1'b1, ADDR_CFG, 32'h1E);
      lpb <= 1'b1;
      wait_rst(1'b1);
      chk(core_reset, 1'b1);
      lpb <= 1'b0;
      wait_rst(1'b0);
      bus(1'b0, ADDR_CAUSE, 32'h0);
      chk(r[CAUSE_BOR_N], 1'b0);
      bus(1'b1, ADDR_CFG, 32'h7F);
      bus(1'b1, ADDR_CAUSE, CAUSE_RST);
   endtask
   task automatic t_prog;
      bus(1'b1, ADDR_CFG, 32'h6F);
      press <= 1'b1;
      prog <= 1'b1;
      cyc(4);
      chk(core_reset, 1'b1);
      prog <= 1'b0;
      cyc(LF * 8 + 40);
      chk(core_reset, 1'b1);
      press <= 1'b0;
      wait_rst(1'b0);
      chk(n >= 10 && n <= 24, 1'b1);
      prog <= 1'b1;
      cyc(4);
      prog <= 1'b0;
      wait_rst(1'b0);
      chk(n >= 30 && n < 5000, 1'b1);
      bus(1'b1, ADDR_CFG, 32'h7F);
   endtask
   task automatic t_wdt;
      wait_rst(1'b1);
      chk(core_reset, 1'b1);
      wait_rst(1'b0);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(r[STAT_TO_N], 1'b0);
      bus(1'b0, ADDR_CAUSE, 32'h0);
      chk(r[CAUSE_WDT], 1'b1);
   endtask
   initial begin
      cyc(8);
      hresetn <= 1'b1;
      t_boot;
      t_pin;
      t_off;
      t_sw;
      t_stack;
      t_lp;
      t_prog;
      t_wdt;
      close_out;
   end
   // Run needs under a thousand cycles; this is forty times that
   initial begin
      #(40000 * 50);
      err_count++;
      close_out;
   end
endmodule
